//--- rtl/afecr_regs.sv
/*
 APB register bank for the analog front end: clock source, sampling phase,
 gains, offsets, sync separation, slicer levels, source and polarity choices.
 Assumes the automatic detection results arrive asynchronously from the sync
 processor and that the analog blocks read the control outputs directly.
 Assumes byte lane 0 carries every register; lanes 1 to 3 are ignored.
 Assumes software keeps the slicer enter level below the exit level.
 Assumes reset is held long enough for the detector flops to settle.
*/
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module afecr_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire afecr_pkg::afecr_sel_t auto_sel,
   output afecr_pkg::afecr_sel_t eff_sel,
   output afecr_pkg::afecr_ctrl_t ctrl
);
   import afecr_pkg::*;

   // ==========================================================
   // Register storage
   logic clk_src_r;
   logic [PHASE_W-1:0] phase_r;
   logic [NUM_CH-1:0][7:0] gain_r;
   logic [NUM_CH-1:0][7:0] target_r;
   logic [NUM_CH-1:0][7:0] offset_r;
   logic [7:0] sep_width_r;
   logic [SLICE_W-1:0] enter_r;
   logic [SLICE_W-1:0] exit_r;
   logic [7:0] source_sel_r;
   logic [7:0] pol_coast_r;
   logic clamp_fb_r;

   // Detector path: two sync stages, then the resolved flop
   logic [NUM_AUTO-1:0] auto_meta_r;
   logic [NUM_AUTO-1:0] auto_sync_r;
   afecr_sel_t auto_s;
   afecr_sel_t eff_nxt;
   afecr_sel_t eff_r;
   afecr_ctrl_t ctrl_nxt;
   afecr_ctrl_t ctrl_r;

   // Bus side
   logic [IDX_W-1:0] idx;
   logic wr_en;
   logic rd_en;
   logic mapped;
   logic [7:0] rd_byte;
   logic [31:0] prdata_r;
   logic pslverr_nxt;

   // Unmapped or misaligned words answer with an error
   function automatic logic idx_mapped(input logic [IDX_W-1:0] i);
      logic hit;
      hit = 1'b0;
      unique case (i)
         IDX_CLK_SRC,
         IDX_PHASE,
         IDX_RED_GAIN,
         IDX_GREEN_GAIN,
         IDX_BLUE_GAIN,
         IDX_RED_TARGET,
         IDX_RED_OFFSET,
         IDX_GREEN_TARGET,
         IDX_GREEN_OFFSET,
         IDX_BLUE_TARGET,
         IDX_BLUE_OFFSET,
         IDX_SEP_WIDTH,
         IDX_SLICE_ENTER,
         IDX_SLICE_EXIT,
         IDX_SOURCE_SEL,
         IDX_POL_COAST,
         IDX_CLAMP_FB,
         IDX_EFFECTIVE: hit = 1'b1;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction : idx_mapped

   // Excess-128 register to signed offset
   function automatic logic [8:0] excess_to_signed(input logic [7:0] v);
      return {1'b0, v} - OFFSET_MID;
   endfunction : excess_to_signed

   // ==========================================================
   // APB decode: zero wait states, byte lane 0 carries each register
   assign idx = paddr[IDX_LSB +: IDX_W];
   assign mapped = idx_mapped(idx) && (paddr[31:IDX_LSB+IDX_W] == '0)
                   && (paddr[IDX_LSB-1:0] == '0);
   // Lane 0 masked: the write is dropped and no error is raised
   assign wr_en = psel && penable && pwrite && mapped && pstrb[0];
   assign rd_en = psel && !penable && !pwrite;
   // Every register is a plain flop, so no access needs a wait state
   assign pready = 1'b1;
   // The error flop holds only through the access cycle it belongs to
   assign pslverr_nxt = psel && !penable && !mapped;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else if (psel && penable) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= pslverr_nxt;
      end
   end

   // ==========================================================
   // Writable registers, one process each
   // True for a lane 0 write aimed at one index
   function automatic logic wr_hit(
      input logic en,
      input logic [IDX_W-1:0] at,
      input logic [IDX_W-1:0] which
   );
      return en && (at == which);
   endfunction : wr_hit

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_src_r <= RST_CLK_SRC[CLK_SRC_BIT];
      end else if (wr_hit(wr_en, idx, IDX_CLK_SRC)) begin
         clk_src_r <= pwdata[CLK_SRC_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_r <= RST_PHASE;
      end else if (wr_hit(wr_en, idx, IDX_PHASE)) begin
         phase_r <= pwdata[PHASE_LSB +: PHASE_W];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sep_width_r <= RST_SEP_WIDTH;
      end else if (wr_hit(wr_en, idx, IDX_SEP_WIDTH)) begin
         sep_width_r <= pwdata[7:0];
      end
   end

   // No ordering check: keeping enter below exit is up to software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enter_r <= RST_SLICE;
      end else if (wr_hit(wr_en, idx, IDX_SLICE_ENTER)) begin
         enter_r <= pwdata[SLICE_LSB +: SLICE_W];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exit_r <= RST_SLICE;
      end else if (wr_hit(wr_en, idx, IDX_SLICE_EXIT)) begin
         exit_r <= pwdata[SLICE_LSB +: SLICE_W];
      end
   end

   // Manual sync, channel, interface and polarity choices only show where their override bit is set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         source_sel_r <= RST_SOURCE_SEL;
      end else if (wr_hit(wr_en, idx, IDX_SOURCE_SEL)) begin
         source_sel_r <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pol_coast_r <= RST_POL_COAST;
      end else if (wr_hit(wr_en, idx, IDX_POL_COAST)) begin
         pol_coast_r <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clamp_fb_r <= RST_CLAMP_FB[CLAMP_FB_BIT];
      end else if (wr_hit(wr_en, idx, IDX_CLAMP_FB)) begin
         clamp_fb_r <= pwdata[CLAMP_FB_BIT];
      end
   end

   // Per-channel gain, clamp target and offset share one layout
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      localparam logic [IDX_W-1:0] GAIN_IDX = IDX_RED_GAIN + IDX_W'(c);
      localparam logic [IDX_W-1:0] TGT_IDX = IDX_RED_TARGET + IDX_W'(2 * c);
      localparam logic [IDX_W-1:0] OFS_IDX = IDX_RED_OFFSET + IDX_W'(2 * c);
      // Gains sit at consecutive indices; target and offset interleave
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            gain_r[c] <= RST_GAIN;
         end else if (wr_hit(wr_en, idx, GAIN_IDX)) begin
            gain_r[c] <= pwdata[7:0];
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            target_r[c] <= RST_TARGET;
         end else if (wr_hit(wr_en, idx, TGT_IDX)) begin
            target_r[c] <= pwdata[7:0];
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            offset_r[c] <= RST_OFFSET;
         end else if (wr_hit(wr_en, idx, OFS_IDX)) begin
            offset_r[c] <= pwdata[7:0];
         end
      end
   end

   // ==========================================================
   // Automatic detection results come from another domain: two flops each
   for (genvar b = 0; b < NUM_AUTO; b++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            auto_meta_r[b] <= 1'b0;
         end else begin
            auto_meta_r[b] <= auto_sel[b];
         end
      end

      // Only the second stage is read past this point
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            auto_sync_r[b] <= 1'b0;
         end else begin
            auto_sync_r[b] <= auto_meta_r[b];
         end
      end
   end
   assign auto_s = afecr_sel_t'(auto_sync_r);

   // ==========================================================
   // Effective selections: manual bit when overridden, detector otherwise
   function automatic logic pick(
      input logic ovr,
      input logic manual,
      input logic detected
   );
      return ovr ? manual : detected;
   endfunction : pick

   always_comb begin
      eff_nxt.hsync_from_sync_on_green = pick(source_sel_r[SS_HS_OVR],
         source_sel_r[SS_HS_SRC], auto_s.hsync_from_sync_on_green);
      eff_nxt.vsync_from_sync_on_green = pick(source_sel_r[SS_VS_OVR],
         source_sel_r[SS_VS_SRC], auto_s.vsync_from_sync_on_green);
      eff_nxt.channel = pick(source_sel_r[SS_CH_OVR],
         source_sel_r[SS_CH_SEL], auto_s.channel);
      eff_nxt.digital_interface = pick(source_sel_r[SS_IF_OVR],
         source_sel_r[SS_IF_SEL], auto_s.digital_interface);
      eff_nxt.hsync_active_high = pick(pol_coast_r[PC_HS_OVR],
         pol_coast_r[PC_HS_POL], auto_s.hsync_active_high);
      eff_nxt.vsync_active_high = pick(pol_coast_r[PC_VS_OVR],
         pol_coast_r[PC_VS_POL], auto_s.vsync_active_high);
      eff_nxt.coast_active_high = pick(pol_coast_r[PC_CO_OVR],
         pol_coast_r[PC_CO_POL], auto_s.coast_active_high);
   end

   // ==========================================================
   // Control outputs; a write shows here one edge later
   always_comb begin
      ctrl_nxt.clock_source_select = clk_src_r;
      ctrl_nxt.pll_divide_ratio_used = !clk_src_r;
      ctrl_nxt.phase = phase_r;
      ctrl_nxt.gain = gain_r;
      ctrl_nxt.clamp_target = target_r;
      ctrl_nxt.clamp_feedback = clamp_fb_r;
      for (int c = 0; c < NUM_CH; c++) begin
         if (clamp_fb_r) begin
            // Target plus brightness, each step one output LSB
            // Nine bits hold any sum of two signed bytes, so it never wraps
            ctrl_nxt.offset_code[c] = {target_r[c][7], target_r[c]}
               + excess_to_signed(offset_r[c]);
         end else begin
            ctrl_nxt.offset_code[c] = excess_to_signed(offset_r[c]);
         end
      end
      ctrl_nxt.sep_width = sep_width_r;
      ctrl_nxt.slicer_enter = enter_r;
      ctrl_nxt.slicer_exit = exit_r;
      ctrl_nxt.coast_external = pol_coast_r[PC_CO_SRC];
      ctrl_nxt.coast_filtered_vsync = pol_coast_r[PC_CO_FILT];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= '0;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eff_r <= '0;
      end else begin
         eff_r <= eff_nxt;
      end
   end
   assign ctrl = ctrl_r;
   assign eff_sel = eff_r;

   // ==========================================================
   // Read mux, captured in the setup cycle so prdata is a flop
   always_comb begin
      // Reserved bits and unmapped indices read as zero
      rd_byte = 8'h00;
      unique case (idx)
         IDX_CLK_SRC: rd_byte[CLK_SRC_BIT] = clk_src_r;
         IDX_PHASE: rd_byte[PHASE_LSB +: PHASE_W] = phase_r;
         IDX_RED_GAIN: rd_byte = gain_r[0];
         IDX_GREEN_GAIN: rd_byte = gain_r[1];
         IDX_BLUE_GAIN: rd_byte = gain_r[2];
         IDX_RED_TARGET: rd_byte = target_r[0];
         IDX_RED_OFFSET: rd_byte = offset_r[0];
         IDX_GREEN_TARGET: rd_byte = target_r[1];
         IDX_GREEN_OFFSET: rd_byte = offset_r[1];
         IDX_BLUE_TARGET: rd_byte = target_r[2];
         IDX_BLUE_OFFSET: rd_byte = offset_r[2];
         IDX_SEP_WIDTH: rd_byte = sep_width_r;
         IDX_SLICE_ENTER: rd_byte[SLICE_LSB +: SLICE_W] = enter_r;
         IDX_SLICE_EXIT: rd_byte[SLICE_LSB +: SLICE_W] = exit_r;
         IDX_SOURCE_SEL: rd_byte = source_sel_r;
         IDX_POL_COAST: rd_byte = pol_coast_r;
         IDX_CLAMP_FB: rd_byte[CLAMP_FB_BIT] = clamp_fb_r;
         // Resolved choices so software can see what auto mode picked
         IDX_EFFECTIVE: rd_byte = {1'b0, eff_r};
         default: rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h00000000;
      end else if (rd_en) begin
         // Unmapped reads return zero alongside the error
         prdata_r <= mapped ? {24'h000000, rd_byte} : 32'h00000000;
      end
   end
   assign prdata = prdata_r;

endmodule : afecr_regs

//--- include/afecr_pkg.sv
/*
 Register indices, field positions, reset values and carrier types for the
 analog front end control register bank.
 Assumes a 32-bit APB master; byte address is four times the register index.
*/
package afecr_pkg;

   // ==========================================================
   // Register indices
   localparam logic [7:0] IDX_CLK_SRC = 8'h03;
   localparam logic [7:0] IDX_PHASE = 8'h04;
   localparam logic [7:0] IDX_RED_GAIN = 8'h05;
   localparam logic [7:0] IDX_GREEN_GAIN = 8'h06;
   localparam logic [7:0] IDX_BLUE_GAIN = 8'h07;
   localparam logic [7:0] IDX_RED_TARGET = 8'h08;
   localparam logic [7:0] IDX_RED_OFFSET = 8'h09;
   localparam logic [7:0] IDX_GREEN_TARGET = 8'h0A;
   localparam logic [7:0] IDX_GREEN_OFFSET = 8'h0B;
   localparam logic [7:0] IDX_BLUE_TARGET = 8'h0C;
   localparam logic [7:0] IDX_BLUE_OFFSET = 8'h0D;
   localparam logic [7:0] IDX_SEP_WIDTH = 8'h0E;
   localparam logic [7:0] IDX_SLICE_ENTER = 8'h0F;
   localparam logic [7:0] IDX_SLICE_EXIT = 8'h10;
   localparam logic [7:0] IDX_SOURCE_SEL = 8'h11;
   localparam logic [7:0] IDX_POL_COAST = 8'h12;
   localparam logic [7:0] IDX_CLAMP_FB = 8'h1C;
   localparam logic [7:0] IDX_EFFECTIVE = 8'h1D;
   localparam int IDX_LSB = 2;
   localparam int IDX_W = 8;

   // ==========================================================
   // Field positions
   localparam int CLK_SRC_BIT = 2;
   localparam int PHASE_LSB = 3;
   localparam int PHASE_W = 5;
   localparam int SLICE_LSB = 2;
   localparam int SLICE_W = 6;
   localparam int CLAMP_FB_BIT = 7;
   localparam int SS_HS_SRC = 7;
   localparam int SS_HS_OVR = 6;
   localparam int SS_VS_SRC = 5;
   localparam int SS_VS_OVR = 4;
   localparam int SS_CH_SEL = 3;
   localparam int SS_CH_OVR = 2;
   localparam int SS_IF_SEL = 1;
   localparam int SS_IF_OVR = 0;
   localparam int PC_HS_POL = 7;
   localparam int PC_HS_OVR = 6;
   localparam int PC_VS_POL = 5;
   localparam int PC_VS_OVR = 4;
   localparam int PC_CO_POL = 3;
   localparam int PC_CO_OVR = 2;
   localparam int PC_CO_SRC = 1;
   localparam int PC_CO_FILT = 0;

   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_CLK_SRC = 8'h00;
   localparam logic [PHASE_W-1:0] RST_PHASE = 5'h10;
   localparam logic [7:0] RST_GAIN = 8'h80;
   localparam logic [7:0] RST_TARGET = 8'h00;
   localparam logic [7:0] RST_OFFSET = 8'h80;
   localparam logic [7:0] RST_SEP_WIDTH = 8'h20;
   localparam logic [SLICE_W-1:0] RST_SLICE = 6'h10;
   localparam logic [7:0] RST_SOURCE_SEL = 8'h00;
   localparam logic [7:0] RST_POL_COAST = 8'hA9;
   localparam logic [7:0] RST_CLAMP_FB = 8'h00;
   // Excess-128 midpoint of the offset register
   localparam logic [8:0] OFFSET_MID = 9'h080;
   localparam int NUM_CH = 3;
   localparam int NUM_AUTO = 7;

   // ==========================================================
   // Carrier types
   typedef struct packed {
      logic hsync_from_sync_on_green;
      logic vsync_from_sync_on_green;
      logic channel;
      logic digital_interface;
      logic hsync_active_high;
      logic vsync_active_high;
      logic coast_active_high;
   } afecr_sel_t;

   typedef struct packed {
      logic clock_source_select;
      logic pll_divide_ratio_used;
      logic [PHASE_W-1:0] phase;
      logic [NUM_CH-1:0][7:0] gain;
      logic [NUM_CH-1:0][7:0] clamp_target;
      logic [NUM_CH-1:0][8:0] offset_code;
      logic clamp_feedback;
      logic [7:0] sep_width;
      logic [SLICE_W-1:0] slicer_enter;
      logic [SLICE_W-1:0] slicer_exit;
      logic coast_external;
      logic coast_filtered_vsync;
   } afecr_ctrl_t;

endpackage : afecr_pkg

//--- testbench/afecr_regs_asserts.sv
/*
 Checker for the front end control register bank, watching top ports only.
 Assumes byte address = 4 * index and the bind below.
*/
`timescale 1ns/1ps
module afecr_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire afecr_pkg::afecr_sel_t auto_sel,
   input wire afecr_pkg::afecr_sel_t eff_sel,
   input wire afecr_pkg::afecr_ctrl_t ctrl
);
   import afecr_pkg::*;
   logic go;
   logic [7:0] ix;
   assign go = psel && penable && pwrite && pstrb[0] && paddr[1:0] == 2'b00;
   assign ix = paddr[9:2];
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================================
   // Ready, misalignment and write effects; writes checked two edges on so either output timing passes
   a_ready_high: assert property (pready) else $error("ready low");
   a_clk_source: assert property (go && ix == IDX_CLK_SRC |-> ##2
      ctrl.clock_source_select == $past(pwdata[2], 2) &&
      ctrl.pll_divide_ratio_used != ctrl.clock_source_select) else $error("clock source");
   a_phase_write: assert property (go && ix == IDX_PHASE |-> ##2
      ctrl.phase == $past(pwdata[7:3], 2)) else $error("phase");
   a_gain_write: assert property (go && ix == IDX_RED_GAIN |-> ##2
      ctrl.gain[0] == $past(pwdata[7:0], 2)) else $error("gain");
   a_target_write: assert property (go && ix == IDX_RED_TARGET |-> ##2
      ctrl.clamp_target[0] == $past(pwdata[7:0], 2)) else $error("target");
   a_offset_abs: assert property (go && ix == IDX_RED_OFFSET && !ctrl.clamp_feedback
      |-> ##2 ctrl.offset_code[0] == {1'b0, $past(pwdata[7:0], 2)} - 9'h080)
      else $error("offset");
   a_sep_write: assert property (go && ix == IDX_SEP_WIDTH |-> ##2
      ctrl.sep_width == $past(pwdata[7:0], 2)) else $error("separator");
   a_coast_write: assert property (go && ix == IDX_POL_COAST |-> ##2
      {ctrl.coast_external, ctrl.coast_filtered_vsync} == $past(pwdata[1:0], 2))
      else $error("coast");
   a_hsrc_manual: assert property (go && ix == IDX_SOURCE_SEL && pwdata[6] |-> ##2
      eff_sel.hsync_from_sync_on_green == $past(pwdata[7], 2)) else $error("hsync source");
   a_chan_manual: assert property (go && ix == IDX_SOURCE_SEL && pwdata[2] |-> ##2
      eff_sel.channel == $past(pwdata[3], 2)) else $error("channel");
   a_hpol_manual: assert property (go && ix == IDX_POL_COAST && pwdata[6] |-> ##2
      eff_sel.hsync_active_high == $past(pwdata[7], 2)) else $error("hsync polarity");
   a_bad_align: assert property (psel && penable && paddr[1:0] != 2'b00 |->
      pslverr) else $error("misaligned");
endmodule : afecr_chk
bind afecr_regs afecr_chk afecr_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .auto_sel(auto_sel),
   .eff_sel(eff_sel), .ctrl(ctrl));

//--- testbench/test_analog_frontend_control_regs.sv
/*
 Self-checking bench for the front end control register bank.
 Assumes the checker is bound in from its own file.
*/
`timescale 1ns/1ps
module test_analog_frontend_control_regs;
   import afecr_pkg::*;
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic [3:0] pstrb, sb;
   logic [7:0] v;
   afecr_sel_t auto_sel, eff_sel;
   afecr_ctrl_t ctrl;
   int fail_count = 0;
   int checks_done = 0;
   int seed = 81;
   int regs[$] = '{3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17, 18, 28};
   logic [7:0] mdl [0:31];

   always #20 pclk = ~pclk;

   afecr_regs afecr_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .auto_sel(auto_sel),
      .eff_sel(eff_sel), .ctrl(ctrl));

   // ==========================================================
   // Model
   function automatic logic [7:0] msk(input int i);
      case (i)
         3: return 8'h04;
         4: return 8'hF8;
         15, 16: return 8'hFC;
         28: return 8'h80;
         default: return 8'hFF;
      endcase
   endfunction : msk

   function automatic logic [7:0] rst(input int i);
      case (i)
         3, 8, 10, 12, 17, 28: return 8'h00;
         14: return 8'h20;
         15, 16: return 8'h40;
         18: return 8'hA9;
         default: return 8'h80;
      endcase
   endfunction : rst

   function automatic afecr_ctrl_t exp_ctrl();
      afecr_ctrl_t c;
      c.clock_source_select = mdl[3][2];
      c.pll_divide_ratio_used = !mdl[3][2];
      c.phase = mdl[4][7:3];
      for (int k = 0; k < 3; k++) begin
         c.gain[k] = mdl[5 + k];
         c.clamp_target[k] = mdl[8 + 2 * k];
         // Modulo 512 sum keeps the signed meaning of both terms
         c.offset_code[k] = {1'b0, mdl[9 + 2 * k]} - 9'h080 +
            (mdl[28][7] ? {mdl[8 + 2 * k][7], mdl[8 + 2 * k]} : 9'h000);
      end
      c.clamp_feedback = mdl[28][7];
      c.sep_width = mdl[14];
      c.slicer_enter = mdl[15][7:2];
      c.slicer_exit = mdl[16][7:2];
      c.coast_external = mdl[18][1];
      c.coast_filtered_vsync = mdl[18][0];
      return c;
   endfunction : exp_ctrl

   function automatic afecr_sel_t exp_sel();
      afecr_sel_t s;
      s = auto_sel;
      if (mdl[17][6]) s.hsync_from_sync_on_green = mdl[17][7];
      if (mdl[17][4]) s.vsync_from_sync_on_green = mdl[17][5];
      if (mdl[17][2]) s.channel = mdl[17][3];
      if (mdl[17][0]) s.digital_interface = mdl[17][1];
      if (mdl[18][6]) s.hsync_active_high = mdl[18][7];
      if (mdl[18][4]) s.vsync_active_high = mdl[18][5];
      if (mdl[18][2]) s.coast_active_high = mdl[18][3];
      return s;
   endfunction : exp_sel

   // ==========================================================
   // Tasks
   task automatic chk(input logic [127:0] seen, input logic [127:0] want);
      checks_done++;
      if (seen !== want) begin
         fail_count++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, want);
      end
   endtask : chk

   task automatic apb(input logic w, input int a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= 32'(a);
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never gets an answer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input int i);
      apb(1'b0, i * 4, 32'h0);
      chk({err, rd}, {9'h0, mdl[i]});
   endtask : rdchk

   task automatic do_reset();
      presetn <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      foreach (regs[k]) mdl[regs[k]] = rst(regs[k]);
      foreach (regs[k]) rdchk(regs[k]);
      chk(ctrl, exp_ctrl());
      $display("reset test done");
   endtask : do_reset

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : give_verdict

   // ==========================================================
   // Sequence
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite} = 3'b000;
      paddr = 32'h0;
      pwdata = 32'h0;
      pstrb = 4'hF;
      auto_sel = '0;
      do_reset();
      repeat (8) begin
         auto_sel <= 7'($random(seed));
         foreach (regs[k]) begin
            v = 8'($random(seed));
            // Enter stays below both the reset exit level and any exit written
            if (regs[k] == 15) v[7:6] = 2'b00;
            if (regs[k] == 16) v[7] = 1'b1;
            sb = 4'($random(seed));
            pstrb <= sb;
            apb(1'b1, regs[k] * 4, {24'($random(seed)), v});
            chk(err, 1'b0);
            if (sb[0]) mdl[regs[k]] = v & msk(regs[k]);
         end
         repeat (4) @(posedge pclk);
         chk(ctrl, exp_ctrl());
         chk(eff_sel, exp_sel());
         foreach (regs[k]) rdchk(regs[k]);
         mdl[29] = {1'b0, exp_sel()};
         rdchk(29);
      end
      $display("random test done");
      pstrb <= 4'hF;
      apb(1'b0, 32'h80, 32'h0);
      chk({err, rd}, {1'b1, 32'h0});
      apb(1'b1, 13 * 4 + 2, 32'h55);
      chk(err, 1'b1);
      apb(1'b1, 29 * 4, 32'hFF);
      rdchk(29);
      rdchk(13);
      $display("refusal test done");
      do_reset();
      give_verdict();
   end

   initial begin
      repeat (6000) @(posedge pclk);
      fail_count++;
      give_verdict();
   end
endmodule : test_analog_frontend_control_regs
